/* rtl/hrc_regs.svh */
// register and timing constants for the hidden clock access controller
`ifndef HRC_REGS_SVH
`define HRC_REGS_SVH
`define HRC_KEY_B0 8'hC5
`define HRC_KEY_B1 8'h3A
`define HRC_KEY_B2 8'hA3
`define HRC_KEY_B3 8'h5C
`define HRC_KEY_BITS 7'h40
`define HRC_XFER_BITS 7'h40
`define HRC_BIT_LAST 7'h3F
`define HRC_HOUR_MODE_BIT 3'h7
`define HRC_HOUR_PM_BIT 3'h5
`define HRC_DAY_RSTIGN_BIT 3'h4
`define HRC_DAY_OSCOFF_BIT 3'h5
`define HRC_DAY_REG 3'h4
`define HRC_HOUR_REG 3'h3
// strobe timing at 100 MHz
`define HRC_T_STROBE_NS 150
`define HRC_T_RECOV_NS 20
`define HRC_CLK_NS 10
`define HRC_STROBE_CYC ((`HRC_T_STROBE_NS + `HRC_CLK_NS - 1) / `HRC_CLK_NS)
`define HRC_RECOV_CYC ((`HRC_T_RECOV_NS + `HRC_CLK_NS - 1) / `HRC_CLK_NS)
`endif

/* rtl/hrc_pkg.sv */
// types for the hidden clock access controller
package hrc_pkg;
    typedef enum logic [6:0] {
        HRC_IDLE   = 7'h01,
        HRC_SETUP  = 7'h02,
        HRC_STROBE = 7'h04,
        HRC_RECOV  = 7'h08,
        HRC_NEXT   = 7'h10,
        HRC_DONE   = 7'h20,
        HRC_ABORT  = 7'h40
    } hrc_state_t;
    typedef enum logic [1:0] {
        HRC_OP_NONE = 2'h0,
        HRC_OP_READ = 2'h1,
        HRC_OP_WRITE = 2'h2
    } hrc_op_t;
endpackage

/* rtl/hrc_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module hrc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
    // storage has no reset; contents qualified by count
    always_ff @(posedge CLK) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

/* rtl/hrc_host.sv */
// host controller driving the hidden clock behind a byte-wide memory port
`timescale 1ns/1ns
`include "hrc_regs.svh"
// Overview of operation
// - host holds address through write and recovers write strobe high before next
// - host keeps output enable high during writes; device releases bus
// - host uses one scratch address for all key writes
// - host writes clock registers as whole 8-bit groups
// - key is C5 3A A3 5C C5 3A A3 5C, each byte lsb first
module hrc_host #(
    parameter int STROBE_CYC = `HRC_STROBE_CYC,
    parameter int RECOV_CYC = `HRC_RECOV_CYC,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [14:0] REQ_SCRATCH_ADDR,
    input wire logic [63:0] REQ_WDATA,
    output logic RSP_VALID,
    input wire logic RSP_READY,
    output logic [63:0] RSP_RDATA,
    output logic BUSY,
    output logic [14:0] MEM_ADDR,
    output logic MEM_CE_N,
    output logic MEM_WE_N,
    output logic MEM_OE_N,
    output logic [7:0] MEM_DQ_OUT,
    output logic MEM_DQ_OE,
    input wire logic [7:0] MEM_DQ_IN,
    output logic MEM_RST_N
);
    import hrc_pkg::*;

    // ----------------------------------------
    // sequence state
    // ----------------------------------------
    localparam logic [63:0] KEY = {`HRC_KEY_B3, `HRC_KEY_B2, `HRC_KEY_B1, `HRC_KEY_B0,
                                   `HRC_KEY_B3, `HRC_KEY_B2, `HRC_KEY_B1, `HRC_KEY_B0};
    hrc_state_t st_q, st_d;
    hrc_op_t op_q, op_d;
    logic [1:0] phase_q, phase_d;
    logic [6:0] bit_q, bit_d;
    logic [7:0] tim_q, tim_d;
    logic [63:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic [14:0] addr_q, addr_d;
    logic ce_q, ce_d, we_q, we_d, oe_q, oe_d, dqoe_q, dqoe_d;
    logic rdy_q, rdy_d, busy_q, busy_d, rstn_q, rstn_d;
    logic [7:0] dqo_q, dqo_d;
    logic rsp_valid, fifo_in_ready, fifo_out_ready, push;
    logic [63:0] fifo_data;
    logic rspv_q, rspv_d;
    logic [63:0] rspd_q, rspd_d;

    // phase: 0 = opening read, 1 = key, 2 = transfer
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        phase_d = phase_q;
        bit_d = bit_q;
        tim_d = tim_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        addr_d = addr_q;
        ce_d = ce_q;
        we_d = we_q;
        oe_d = oe_q;
        dqoe_d = dqoe_q;
        dqo_d = dqo_q;
        // reset pin is never pulsed, a pulse would abort a transfer
        rstn_d = 1'b1;
        push = 1'b0;
        case (st_q)
            HRC_IDLE: begin
                if (REQ_VALID) begin
                    op_d = REQ_WRITE ? HRC_OP_WRITE : HRC_OP_READ;
                    addr_d = REQ_SCRATCH_ADDR;
                    wdat_d = REQ_WDATA;
                    phase_d = 2'h0;
                    bit_d = '0;
                    st_d = HRC_SETUP;
                end
            end
            HRC_SETUP: begin
                // address stable first; strobe begins a cycle later
                ce_d = 1'b0;
                if (phase_q == 2'h0 || (phase_q == 2'h2 && op_q == HRC_OP_READ)) begin
                    oe_d = 1'b0;
                    dqoe_d = 1'b0;
                end else begin
                    oe_d = 1'b1;
                    we_d = 1'b0;
                    dqoe_d = 1'b1;
                    // key lsb first; bit 0 of reg 0 first
                    dqo_d = {7'h00, ((phase_q == 2'h1) ? KEY[bit_q[5:0]] : wdat_q[bit_q[5:0]])};
                end
                tim_d = 8'(STROBE_CYC);
                st_d = HRC_STROBE;
            end
            HRC_STROBE: begin
                tim_d = tim_q - 8'h01;
                if (tim_q == 8'h01) begin
                    // sample bit zero at end of read
                    if (phase_q == 2'h2 && op_q == HRC_OP_READ) begin
                        rdat_d[bit_q[5:0]] = MEM_DQ_IN[0];
                    end
                    // write ends on the first rising strobe
                    ce_d = 1'b1;
                    we_d = 1'b1;
                    oe_d = 1'b1;
                    tim_d = 8'(RECOV_CYC);
                    st_d = HRC_RECOV;
                end
            end
            HRC_RECOV: begin
                dqoe_d = 1'b0;
                tim_d = tim_q - 8'h01;
                if (tim_q <= 8'h01) begin
                    st_d = HRC_NEXT;
                end
            end
            HRC_NEXT: begin
                st_d = HRC_SETUP;
                if (phase_q == 2'h0) begin
                    phase_d = 2'h1;
                    bit_d = '0;
                end else if (bit_q == `HRC_BIT_LAST) begin
                    bit_d = '0;
                    if (phase_q == 2'h1) begin
                        phase_d = 2'h2;
                    end else begin
                        st_d = HRC_DONE;
                    end
                end else begin
                    bit_d = bit_q + 7'h01;
                end
            end
            HRC_DONE: begin
                // whole 64 bits written or read as full groups
                if (fifo_in_ready) begin
                    push = 1'b1;
                    st_d = HRC_IDLE;
                end
            end
            default: begin
                st_d = HRC_IDLE;
            end
        endcase
        rdy_d = (st_d == HRC_IDLE);
        busy_d = !rdy_d;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q <= HRC_IDLE;
            op_q <= HRC_OP_NONE;
            phase_q <= 2'h0;
            bit_q <= '0;
            tim_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            addr_q <= '0;
            ce_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            dqoe_q <= 1'b0;
            dqo_q <= 8'h00;
            rdy_q <= 1'b1;
            busy_q <= 1'b0;
            rstn_q <= 1'b1;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            phase_q <= phase_d;
            bit_q <= bit_d;
            tim_q <= tim_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            addr_q <= addr_d;
            ce_q <= ce_d;
            we_q <= we_d;
            oe_q <= oe_d;
            dqoe_q <= dqoe_d;
            dqo_q <= dqo_d;
            rdy_q <= rdy_d;
            busy_q <= busy_d;
            rstn_q <= rstn_d;
        end
    end

    // ----------------------------------------
    // result buffer, stalls the sequencer when full
    // ----------------------------------------
    hrc_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
        .CLK(CLK),
        .RST(RST),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(op_q == HRC_OP_READ ? rdat_q : wdat_q),
        .out_valid(rsp_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_data)
    );

    // ----------------------------------------
    // response stage, so the result port comes from flip-flops
    // ----------------------------------------
    always_comb begin
        fifo_out_ready = !rspv_q || RSP_READY;
        rspv_d = rspv_q && !RSP_READY;
        rspd_d = rspd_q;
        if (rsp_valid && fifo_out_ready) begin
            rspv_d = 1'b1;
            rspd_d = fifo_data;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rspv_q <= 1'b0;
            rspd_q <= '0;
        end else begin
            rspv_q <= rspv_d;
            rspd_q <= rspd_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign RSP_VALID = rspv_q;
    assign RSP_RDATA = rspd_q;
    assign REQ_READY = rdy_q;
    assign BUSY = busy_q;
    assign MEM_ADDR = addr_q;
    assign MEM_CE_N = ce_q;
    assign MEM_WE_N = we_q;
    assign MEM_OE_N = oe_q;
    assign MEM_DQ_OUT = dqo_q;
    assign MEM_DQ_OE = dqoe_q;
    assign MEM_RST_N = rstn_q;
endmodule

/* verification/hrc_host_sva.sv */
// port assertions for the hidden clock host controller
`timescale 1ns/1ns
module hrc_host_sva (
    input wire logic CLK,
    input wire logic RST,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic RSP_READY,
    input wire logic [63:0] RSP_RDATA,
    input wire logic BUSY,
    input wire logic [14:0] MEM_ADDR,
    input wire logic MEM_CE_N,
    input wire logic MEM_WE_N,
    input wire logic MEM_OE_N,
    input wire logic MEM_DQ_OE,
    input wire logic MEM_RST_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    addr_hold_a: assert property ((!MEM_CE_N && !MEM_WE_N) |=> MEM_WE_N || $stable(MEM_ADDR))
        else $error("address moved inside a write");
    we_recover_a: assert property ($rose(MEM_WE_N) |=> MEM_WE_N)
        else $error("write strobe recovery too short");
    write_oe_a: assert property (!MEM_WE_N |-> MEM_OE_N && MEM_DQ_OE)
        else $error("output enable low or data undriven in write");
    read_release_a: assert property (!MEM_OE_N |-> !MEM_DQ_OE)
        else $error("host drives data while device outputs");
    strobe_width_a: assert property ($fell(MEM_CE_N) |-> !MEM_CE_N [*2])
        else $error("chip select pulse too short");
    rsp_hold_a: assert property (RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_RDATA))
        else $error("response dropped before accepted");
    take_busy_a: assert property (REQ_VALID && REQ_READY |=> BUSY)
        else $error("request taken without going busy");
    open_read_a: assert property (REQ_VALID && REQ_READY |=> ##1 !MEM_CE_N && !MEM_OE_N && MEM_WE_N)
        else $error("sequence did not open with a read");
    idle_quiet_a: assert property (!BUSY |-> MEM_CE_N && !MEM_DQ_OE)
        else $error("bus active while idle");
    rst_pin_a: assert property (MEM_RST_N)
        else $error("device reset pin pulled low");
endmodule
bind hrc_host hrc_host_sva u_sva (.CLK, .RST, .REQ_VALID, .REQ_READY, .RSP_VALID, .RSP_READY,
    .RSP_RDATA, .BUSY, .MEM_ADDR, .MEM_CE_N, .MEM_WE_N, .MEM_OE_N, .MEM_DQ_OE, .MEM_RST_N);

/* verification/hrc_phantom_model.sv */
// behavioural model of the hidden clock behind its byte-wide memory
`timescale 1ns/1ns
module hrc_phantom_model (
    input wire logic CLK,
    input wire logic [14:0] ADDR,
    input wire logic CE_N,
    input wire logic WE_N,
    input wire logic OE_N,
    input wire logic [7:0] DQ_WR,
    output logic [7:0] DQ_RD
);
    localparam logic [63:0] KEY = 64'h5CA3_3AC5_5CA3_3AC5;
    logic [7:0] mem [0:32767];
    // control bits start set, oscillator off so the registers stand
    logic [63:0] regs = 64'h0000_0030_0000_0000;
    logic ce_q = 1'b1;
    logic wr_c = 1'b0;
    logic [7:0] wbyte = 8'h00;
    logic [7:0] last = 8'h00;
    int ptr = 0;
    int xfer = 0;
    // released bus shows a moving pattern, not the last value
    always_comb begin
        DQ_RD = ~last;
        if (!CE_N && !OE_N && WE_N) begin
            DQ_RD = (xfer > 0) ? {7'h00, regs[64 - xfer]} : mem[ADDR];
        end
    end
    always @(posedge CLK) begin
        ce_q <= CE_N;
        last <= DQ_RD;
        // write spans the overlap of both strobes low
        if (!CE_N && !WE_N) begin
            wr_c <= 1'b1;
            wbyte <= DQ_WR;
        end
        if (!ce_q && CE_N) begin
            wr_c <= 1'b0;
            if (xfer > 0) begin
                if (wr_c) regs[64 - xfer] <= wbyte[0];
                xfer <= xfer - 1;
            end else if (!wr_c) begin
                ptr <= 0;
            end else begin
                // key write also lands in memory; a miss freezes
                mem[ADDR] <= wbyte;
                if (ptr < 64) ptr <= (wbyte[0] == KEY[ptr]) ? ptr + 1 : 99;
                if (ptr == 63 && wbyte[0] == KEY[63]) begin
                    ptr <= 0;
                    xfer <= 64;
                end
            end
        end
    end
endmodule

/* verification/hrc_host_bench.sv */
// self-checking bench for the hidden clock host controller
`timescale 1ns/1ns
module hrc_host_bench;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, rsp_ready = 1'b0;
    logic req_ready, rsp_valid, busy, ce_n, we_n, oe_n, dq_oe, rst_n;
    logic [63:0] req_wdata = 64'h0, rsp_rdata;
    logic [14:0] addr;
    logic [7:0] dq_out, dq_rd;
    wire logic [7:0] dq = dq_oe ? dq_out : dq_rd;
    int errors = 0, num_checks = 0, cyc = 0;
    localparam logic [63:0] DFLT = 64'h0000_0030_0000_0000;
    localparam logic [63:0] IMG = 64'h2412_3135_A159_3000;
    hrc_host #(.STROBE_CYC(2), .RECOV_CYC(1), .FIFO_DEPTH(4)) dut (.CLK(clk), .RST(rst),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
        .REQ_SCRATCH_ADDR(15'h1F00), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
        .RSP_READY(rsp_ready), .RSP_RDATA(rsp_rdata), .BUSY(busy), .MEM_ADDR(addr),
        .MEM_CE_N(ce_n), .MEM_WE_N(we_n), .MEM_OE_N(oe_n), .MEM_DQ_OUT(dq_out),
        .MEM_DQ_OE(dq_oe), .MEM_DQ_IN(dq), .MEM_RST_N(rst_n));
    hrc_phantom_model u_dev (.CLK(clk), .ADDR(addr), .CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n),
        .DQ_WR(dq), .DQ_RD(dq_rd));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // request held until the edge that samples ready high
    task automatic send(input logic wr, input logic [63:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask
    task automatic take(input logic [63:0] exp);
        int n;
        logic [63:0] got;
        n = 0;
        @(posedge clk);
        #1;
        rsp_ready = 1'b1;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        got = rsp_rdata;
        @(posedge clk);
        #1;
        rsp_ready = 1'b0;
        chk(got, exp);
    endtask
    task automatic t_default;
        send(1'b0, 64'h0);
        take(DFLT);
        // last key bit is bit 7 of 5c, a zero, parked in the scratch byte
        chk({56'h0, u_dev.mem[15'h1F00]}, 64'h0);
    endtask
    task automatic t_set_get;
        send(1'b1, IMG);
        take(IMG);
        send(1'b0, 64'h0);
        take(IMG);
    endtask
    // five results fill fifo and output stage; the sixth stalls, so a refusal window follows
    task automatic t_full;
        int n;
        n = 0;
        for (int i = 0; i < 6; i++) send(1'b1, IMG + 64'(i));
        repeat (2000) begin
            @(posedge clk);
            #1;
            if (req_ready !== 1'b0) n++;
        end
        chk(64'(n), 64'h0);
        for (int i = 0; i < 6; i++) take(IMG + 64'(i));
        chk({63'h0, rsp_valid}, 64'h0);
        send(1'b0, 64'h0);
        take(IMG + 64'h5);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_default();
        t_set_get();
        t_full();
        results();
    end
endmodule
